// ### ssc_map.svh
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// register byte addresses
`define SSC_ADDR_CTRL 12'h000
`define SSC_ADDR_STAT 12'h004
`define SSC_ADDR_DATA 12'h008
`define SSC_ADDR_PINS 12'h00c
`define SSC_ADDR_EVST 12'h010
`define SSC_ADDR_EVMSK 12'h014
// serial_control fields
`define SSC_CTRL_IE 7
`define SSC_CTRL_EN 6
`define SSC_CTRL_ORD 5
`define SSC_CTRL_MASTER_SELECT_BIT 4
`define SSC_CTRL_CLOCK_POLARITY 3
`define SSC_CTRL_CLOCK_PHASE 2
`define SSC_CTRL_RST 8'h00
// serial_status fields
`define SSC_STAT_FLAG 7
`define SSC_STAT_WCOL 6
`define SSC_STAT_DBL 0
// pin configuration fields
`define SSC_PINS_SS_DIR 0
`define SSC_PINS_MOSI_DIR 1
`define SSC_PINS_MISO_DIR 2
`define SSC_PINS_SCK_DIR 3
`define SSC_PINS_SS_LEVEL 4
`define SSC_PINS_RST 8'h00
// event status / mask fields
`define SSC_EV_DONE 0
`define SSC_EV_FALL 1
`define SSC_EV_COL 2
`define SSC_EV_RST 3'h0
// last bit index and last link edge index of a byte
`define SSC_LAST_BIT 3'h7
`define SSC_LAST_EDGE 5'h0f
// ceiling for one master byte, above the slowest rate's 1024 cycles
`define SSC_RUN_MAX 11'h44c
`endif

// ### ssc_pkg.sv
`default_nettype none
package ssc_pkg;
  typedef enum logic {SSC_M_IDLE, SSC_M_RUN} ssc_state_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } ssc_pins_t;
endpackage
`default_nettype wire

// ### ssc_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`include "ssc_map.svh"
`default_nettype none
module ssc_top import ssc_pkg::*; (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // cpu side
  input wire logic cpu_irq_enable,
  input wire logic irq_vector_ack,
  output var logic irq,
  // serial pins
  input wire ssc_pins_t pin_in,
  output var ssc_pins_t pin_out,
  output var ssc_pins_t pin_oe
);
  logic [7:0] ctrl;
  logic [7:0] pins_cfg;
  logic [7:0] shreg;
  logic [7:0] rx_buf;
  logic flag;
  logic wcol;
  logic dbl;
  logic arm;
  logic [2:0] ev_st;
  logic [2:0] ev_msk;
  ssc_pins_t sync1;
  ssc_pins_t sync2;
  logic sck_d;
  ssc_state_t state;
  logic [6:0] half_cnt;
  logic [4:0] edge_cnt;
  logic [2:0] bit_cnt;
  logic sck_gen;
  logic [31:0] next_rdata;
  logic [10:0] run_len;

  function automatic logic [6:0] ssc_half(input logic [1:0] spr, input logic d);
    logic [6:0] h;
    h = 7'h00;
    case ({d, spr})
      3'b100: h = 7'h00;
      3'b000: h = 7'h01;
      3'b101: h = 7'h03;
      3'b001: h = 7'h07;
      3'b110: h = 7'h0f;
      3'b010: h = 7'h1f;
      3'b111: h = 7'h1f;
      default: h = 7'h3f;
    endcase
    return h;
  endfunction

  // bus decode
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == `SSC_ADDR_CTRL;
  wire hit_stat = paddr == `SSC_ADDR_STAT;
  wire hit_data = paddr == `SSC_ADDR_DATA;
  wire hit_pins = paddr == `SSC_ADDR_PINS;
  wire hit_evst = paddr == `SSC_ADDR_EVST;
  wire hit_evmsk = paddr == `SSC_ADDR_EVMSK;
  wire hit_any = hit_ctrl | hit_stat | hit_data | hit_pins | hit_evst | hit_evmsk;

  // mode decode
  wire en = ctrl[`SSC_CTRL_EN];
  wire master_select_bit = ctrl[`SSC_CTRL_MASTER_SELECT_BIT];
  wire clock_polarity = ctrl[`SSC_CTRL_CLOCK_POLARITY];
  wire clock_phase = ctrl[`SSC_CTRL_CLOCK_PHASE];
  wire ord = ctrl[`SSC_CTRL_ORD];
  wire ss_lo = ~sync2.ss;
  wire slave_act = en & ~master_select_bit & ss_lo;
  wire fallback = en & master_select_bit & ~pins_cfg[`SSC_PINS_SS_DIR] & ss_lo;
  wire running = state == SSC_M_RUN;

  // link edges, slave from sampled clock, master from own divider
  wire s_lead = (sck_d == clock_polarity) & (sync2.sck != clock_polarity);
  wire s_trail = (sck_d != clock_polarity) & (sync2.sck == clock_polarity);
  wire m_tick = running & (half_cnt == 7'h00);
  wire m_lead = m_tick & ~edge_cnt[0];
  wire m_trail = m_tick & edge_cnt[0];
  wire m_done = m_tick & (edge_cnt == `SSC_LAST_EDGE);
  wire s_sample = slave_act & (clock_phase ? s_trail : s_lead);
  wire m_sample = running & master_select_bit & (clock_phase ? m_trail : m_lead);
  wire sample = s_sample | m_sample;
  wire din = master_select_bit ? sync2.miso : sync2.mosi;
  wire [7:0] next_sh = ord ? {din, shreg[7:1]} : {shreg[6:0], din};
  wire byte_done = sample & (bit_cnt == `SSC_LAST_BIT);
  wire done_ev = master_select_bit ? m_done : (byte_done & slave_act);
  wire busy = running | (slave_act & (bit_cnt != 3'h0));
  wire tx_bit = ord ? shreg[0] : shreg[7];

  // data register side effects
  wire data_wr = wr & hit_data;
  wire data_acc = acc & hit_data;
  wire tx_load = data_wr & ~busy;
  wire collide = data_wr & busy;
  wire start = tx_load & en & master_select_bit & ~fallback;
  wire flag_clr = irq_vector_ack | (data_acc & arm);
  wire [2:0] ev_set = {collide, fallback, done_ev};
  wire [2:0] ev_clr = (wr & hit_evst) ? pwdata[2:0] : 3'h0;

  // fallback beats a software write of the master bit in the same cycle
  wire [7:0] wr_ctrl = (wr & hit_ctrl) ? pwdata[7:0] : ctrl;
  wire [7:0] next_ctrl = fallback ? (wr_ctrl & ~(8'h01 << `SSC_CTRL_MASTER_SELECT_BIT)) : wr_ctrl;

  // pin directions; slave forces everything but data-out to input
  wire [3:0] dir_cfg = {pins_cfg[`SSC_PINS_SCK_DIR], pins_cfg[`SSC_PINS_MOSI_DIR],
                        pins_cfg[`SSC_PINS_MISO_DIR], pins_cfg[`SSC_PINS_SS_DIR]};
  wire [3:0] oe_mst = {dir_cfg[3], dir_cfg[2], 1'b0, dir_cfg[0]};
  wire [3:0] oe_slv = {2'b00, dir_cfg[1] & ss_lo, 1'b0};
  wire [3:0] next_oe = en ? (master_select_bit ? oe_mst : oe_slv) : dir_cfg;
  wire next_irq = cpu_irq_enable & ((ctrl[`SSC_CTRL_IE] & flag) | (|(ev_st & ev_msk)));

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata = {24'h00_0000, ctrl};
    end else if (hit_stat) begin
      next_rdata = {24'h00_0000, flag, wcol, 5'h00, dbl};
    end else if (hit_data) begin
      next_rdata = {24'h00_0000, rx_buf};
    end else if (hit_pins) begin
      next_rdata = {24'h00_0000, pins_cfg};
    end else if (hit_evst) begin
      next_rdata = {29'h0000_0000, ev_st};
    end else if (hit_evmsk) begin
      next_rdata = {29'h0000_0000, ev_msk};
    end
  end

  // two-stage synchroniser, third stage for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      sck_d <= 1'b1;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sck_d <= sync2.sck;
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata <= (psel & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SSC_CTRL_RST;
      pins_cfg <= `SSC_PINS_RST;
      dbl <= 1'b0;
      ev_msk <= `SSC_EV_RST;
    end else begin
      ctrl <= next_ctrl;
      if (wr & hit_pins) begin
        pins_cfg <= pwdata[7:0];
      end
      if (wr & hit_stat) begin
        dbl <= pwdata[`SSC_STAT_DBL];
      end
      if (wr & hit_evmsk) begin
        ev_msk <= pwdata[2:0];
      end
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
      wcol <= 1'b0;
      arm <= 1'b0;
      ev_st <= `SSC_EV_RST;
    end else begin
      flag <= done_ev | fallback | (flag & ~flag_clr);
      wcol <= collide | (wcol & ~(data_acc & arm));
      ev_st <= ev_set | (ev_st & ~ev_clr);
      if (rd & hit_stat & (flag | wcol)) begin
        arm <= 1'b1;
      end else if (data_acc) begin
        arm <= 1'b0;
      end
    end
  end

  // shifter; a deselected or disabled slave holds its counter at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      rx_buf <= 8'h00;
    end else begin
      if (tx_load) begin
        shreg <= pwdata[7:0];
        bit_cnt <= 3'h0;
      end else if (~en | fallback | (~master_select_bit & ~ss_lo)) begin
        bit_cnt <= 3'h0;
      end else if (sample) begin
        shreg <= next_sh;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_done) begin
        rx_buf <= next_sh;
      end
    end
  end

  // master clock generator; abandons the byte on fallback or disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SSC_M_IDLE;
      half_cnt <= 7'h00;
      edge_cnt <= 5'h00;
      sck_gen <= 1'b0;
    end else begin
      case (state)
        SSC_M_IDLE: begin
          sck_gen <= clock_polarity;
          edge_cnt <= 5'h00;
          half_cnt <= ssc_half(ctrl[1:0], dbl);
          if (start) begin
            state <= SSC_M_RUN;
          end
        end
        SSC_M_RUN: begin
          if (fallback | ~en | ~master_select_bit) begin
            state <= SSC_M_IDLE;
            sck_gen <= clock_polarity;
          end else if (half_cnt == 7'h00) begin
            sck_gen <= ~sck_gen;
            half_cnt <= ssc_half(ctrl[1:0], dbl);
            edge_cnt <= edge_cnt + 5'h01;
            if (edge_cnt == `SSC_LAST_EDGE) begin
              state <= SSC_M_IDLE;
            end
          end else begin
            half_cnt <= half_cnt - 7'h01;
          end
        end
        default: state <= SSC_M_IDLE;
      endcase
    end
  end

  // pins and interrupt, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
      irq <= 1'b0;
    end else begin
      pin_out <= {sck_gen, tx_bit, tx_bit, pins_cfg[`SSC_PINS_SS_LEVEL]};
      pin_oe <= next_oe;
      irq <= next_irq;
    end
  end

  // saturating run length, so a hung byte cannot wrap back to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len <= 11'h000;
    end else if (!running) begin
      run_len <= 11'h000;
    end else if (run_len != `SSC_RUN_MAX) begin
      run_len <= run_len + 11'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_run_begins;
    start ##1 running;
  endsequence

  property p_fall_clears_master_select_bit;
    fallback |=> !master_select_bit;
  endproperty
  a_fall_clears_master_select_bit: assert property (p_fall_clears_master_select_bit)
    else $error("master bit kept after fallback");

  property p_fall_sets_flag;
    fallback |=> flag ##1 !running;
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag)
    else $error("flag not set on fallback");

  property p_irq_cause;
    (ev_msk == 3'h0) |=> (irq == $past(cpu_irq_enable & ctrl[`SSC_CTRL_IE] & flag));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq does not follow enable and flag");

  property p_ss_reset;
    (en && !master_select_bit && sync2.ss && !tx_load) |=> (bit_cnt == 3'h0);
  endproperty
  a_ss_reset: assert property (p_ss_reset)
    else $error("bit counter not reset while deselected");

  property p_passive;
    (en && !master_select_bit && sync2.ss) |=> $stable(rx_buf);
  endproperty
  a_passive: assert property (p_passive)
    else $error("deselected slave captured data");

  property p_miso_off;
    (en && !master_select_bit && sync2.ss) |=> !pin_oe.miso;
  endproperty
  a_miso_off: assert property (p_miso_off)
    else $error("slave-out driven while deselected");

  property p_slave_inputs;
    (en && !master_select_bit) |=> (!pin_oe.sck && !pin_oe.mosi && !pin_oe.ss);
  endproperty
  a_slave_inputs: assert property (p_slave_inputs)
    else $error("slave drives a pin other than slave-out");

  property p_disabled_idle;
    !en |=> (!running && bit_cnt == 3'h0);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("activity while disabled");

  property p_master_select_bit_stays;
    (!master_select_bit && !(wr && hit_ctrl)) |=> !master_select_bit;
  endproperty
  a_master_select_bit_stays: assert property (p_master_select_bit_stays)
    else $error("master bit restored by hardware");

  property p_ss_plain;
    (en && master_select_bit && pins_cfg[`SSC_PINS_SS_DIR] && !(wr && hit_ctrl)) |=> master_select_bit;
  endproperty
  a_ss_plain: assert property (p_ss_plain)
    else $error("select output disturbed master mode");

  property p_run_begins;
    start |-> s_run_begins;
  endproperty
  a_run_begins: assert property (p_run_begins)
    else $error("master byte did not start");

  property p_run_ends;
    running |-> (run_len != `SSC_RUN_MAX);
  endproperty
  a_run_ends: assert property (p_run_ends)
    else $error("master byte did not finish");

  property p_flag_clear;
    (irq_vector_ack && !done_ev && !fallback) |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by vector");
endmodule
`default_nettype wire

// ### ssc_link_model.sv
`default_nettype none
module ssc_link_model (
  // link lines
  input wire logic miso,
  output var logic sck,
  output var logic mosi,
  output var logic sel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
    rx = 8'h00;
  end
  // sck stands still outside frames; 320 ns period inside
  task automatic frame(input logic [7:0] d, input int nb, input logic lsb, input logic pick);
    int i;
    #7;
    sel_n = ~pick;
    for (i = 0; i < nb; i++) begin
      mosi = lsb ? d[i] : d[7-i];
      #160;
      sck = 1'b1;
      rx = lsb ? {miso, rx[7:1]} : {rx[6:0], miso};
      #160;
      sck = 1'b0;
    end
    #160;
    sel_n = 1'b1;
    mosi = ~mosi;
  endtask
  task automatic hold(input logic v);
    #7;
    sel_n = v;
  endtask
endmodule
`default_nettype wire

// ### spi_select_and_control_tb.sv
`include "ssc_map.svh"
`default_nettype none
module spi_select_and_control_tb import ssc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic cpu_irq_enable, irq_vector_ack, irq, e, miso_free, loop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  ssc_pins_t pin_in, pin_out, pin_oe;
  wire logic m_sck, m_mosi, m_sel_n;
  int n_mismatch, total_checks, cyc;
  // a released slave-out line toggles every clock unless looped, so a stale value never passes
  assign pin_in = {pin_oe.sck ? pin_out.sck : m_sck, pin_oe.mosi ? pin_out.mosi : m_mosi,
    pin_oe.miso ? pin_out.miso : (loop ? pin_out.mosi : miso_free),
    pin_oe.ss ? pin_out.ss : m_sel_n};
  ssc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_irq_enable(cpu_irq_enable), .irq_vector_ack(irq_vector_ack),
    .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  ssc_link_model m (.miso(pin_in.miso), .sck(m_sck), .mosi(m_mosi), .sel_n(m_sel_n));
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) miso_free <= ~miso_free;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctrl_v(input logic ie, en, ord, ms);
    return {24'h0, ie, en, ord, ms, 4'h0};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bound well above the fewer than one thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_irq_enable, irq_vector_ack, presetn, miso_free, loop} = '0;
    {n_mismatch, total_checks, cyc} = '0;
    seed = 32'd66438;
    settle(5);
    presetn <= 1'b1;
    settle(1);
    apb(0, `SSC_ADDR_CTRL, 0);
    chk(r, 32'h0);
    apb(0, 12'h020, 0);
    chk({r[31:1], e}, 32'h1);
    apb(1, `SSC_ADDR_PINS, 32'h04);
    for (int o = 0; o < 2; o++) begin
      seed = lfsr(seed);
      apb(1, `SSC_ADDR_CTRL, ctrl_v(0, 1, o[0], 0));
      apb(1, `SSC_ADDR_DATA, {24'h0, seed[7:0]});
      fork
        m.frame(seed[15:8], 8, o[0], 1'b1);
        begin
          settle(30);
          chk({28'h0, pin_oe}, 32'h2);
        end
      join
      settle(4);
      apb(0, `SSC_ADDR_STAT, 0);
      chk(r, 32'h80);
      apb(0, `SSC_ADDR_DATA, 0);
      chk(r, {24'h0, seed[15:8]});
      chk({24'h0, m.rx}, {24'h0, seed[7:0]});
      apb(0, `SSC_ADDR_STAT, 0);
      chk(r, 32'h0);
    end
    note("slave frames");
    seed = lfsr(seed);
    m.frame(seed[7:0], 3, 1'b1, 1'b1);
    settle(4);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h0);
    m.frame(seed[15:8], 8, 1'b1, 1'b1);
    settle(4);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h80);
    apb(0, `SSC_ADDR_DATA, 0);
    chk(r, {24'h0, seed[15:8]});
    fork
      m.frame(seed[23:16], 8, 1'b1, 1'b0);
      begin
        settle(30);
        chk({28'h0, pin_oe}, 32'h0);
      end
    join
    settle(4);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h0);
    apb(1, `SSC_ADDR_CTRL, 0);
    m.frame(seed[31:24], 8, 1'b1, 1'b1);
    settle(4);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h0);
    note("abort, deselect, disable");
    apb(1, `SSC_ADDR_EVST, 32'h7);
    apb(1, `SSC_ADDR_PINS, 32'h0a);
    apb(1, `SSC_ADDR_CTRL, ctrl_v(1, 1, 0, 1));
    cpu_irq_enable <= 1'b1;
    settle(3);
    chk({28'h0, pin_oe}, 32'hc);
    m.hold(1'b0);
    settle(6);
    apb(0, `SSC_ADDR_CTRL, 0);
    chk(r, ctrl_v(1, 1, 0, 0));
    chk({28'h0, pin_oe}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h80);
    cpu_irq_enable <= 1'b0;
    settle(3);
    chk({31'h0, irq}, 32'h0);
    cpu_irq_enable <= 1'b1;
    m.hold(1'b1);
    settle(6);
    apb(0, `SSC_ADDR_CTRL, 0);
    chk(r, ctrl_v(1, 1, 0, 0));
    irq_vector_ack <= 1'b1;
    settle(1);
    irq_vector_ack <= 1'b0;
    settle(2);
    chk({31'h0, irq}, 32'h0);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h0);
    apb(0, `SSC_ADDR_EVST, 0);
    chk(r, 32'h2);
    apb(1, `SSC_ADDR_EVMSK, 32'h2);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1, `SSC_ADDR_EVMSK, 32'h0);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    apb(1, `SSC_ADDR_EVMSK, 32'h2);
    apb(1, `SSC_ADDR_EVST, 32'h2);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    note("fallback and interrupts");
    apb(1, `SSC_ADDR_PINS, 32'h01);
    apb(1, `SSC_ADDR_CTRL, ctrl_v(0, 1, 0, 1));
    settle(6);
    apb(0, `SSC_ADDR_CTRL, 0);
    chk(r, ctrl_v(0, 1, 0, 1));
    chk({28'h0, pin_oe}, 32'h1);
    note("select as output");
    apb(1, `SSC_ADDR_CTRL, 0);
    apb(1, `SSC_ADDR_PINS, 32'h0a);
    apb(1, `SSC_ADDR_CTRL, ctrl_v(0, 1, 0, 1) | 32'h0d);
    loop <= 1'b1;
    seed = lfsr(seed);
    apb(1, `SSC_ADDR_DATA, {24'h0, seed[7:0]});
    apb(1, `SSC_ADDR_DATA, {24'h0, seed[15:8]});
    settle(150);
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'hc0);
    apb(0, `SSC_ADDR_DATA, 0);
    chk(r, {24'h0, seed[7:0]});
    chk({28'h0, pin_out}, {28'h0, 1'b1, seed[7], seed[7], 1'b0});
    apb(0, `SSC_ADDR_STAT, 0);
    chk(r, 32'h0);
    apb(0, `SSC_ADDR_EVST, 0);
    chk(r, 32'h5);
    note("master loopback");
    give_verdict();
  end
endmodule
`default_nettype wire
